// ### common/counter_array_consts.vh
`ifndef COUNTER_ARRAY_CONSTS_VH
`define COUNTER_ARRAY_CONSTS_VH
// register addresses (8-bit registers on a plain port)
`define ADDR_RUN_FLAGS 5'h00
`define ADDR_ARRAY_MODE 5'h01
`define ADDR_COUNT_LO 5'h02
`define ADDR_COUNT_HI 5'h03
`define ADDR_MODE_BASE 5'h08
`define ADDR_VAL_LO_BASE 5'h10
`define ADDR_VAL_HI_BASE 5'h18
// run and flags register fields
`define RF_OVERFLOW 7
`define RF_RUN 6
// array mode register fields
`define AM_IDLE_STOP 7
`define AM_WDOG_EN 6
`define AM_SRC_HI 2
`define AM_SRC_LO 1
`define AM_OVF_IRQ_EN 0
// module mode register fields
`define MM_IRQ_EN 0
`define MM_PWM 1
`define MM_TOGGLE 2
`define MM_MATCH_FLAG 3
`define MM_CAP_FALL 4
`define MM_CAP_RISE 5
`define MM_COMP_EN 6
// prescaler divide ratios of the oscillator
`define DIV_BY_4 8'h04
`define DIV_BY_16 8'h10
`define DIV_BY_64 8'h40
`define RESET_BYTE 8'h00
`endif

// ### dv/counter_array_sva.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// flag and register port checks
// ----------------------------------------
module counter_array_sva #(
  parameter NUM_MODULES = 5,
  parameter COUNT_WIDTH = 16
) (
  // clock and reset
  input wire sys_clk,
  input wire rst_b,
  // register port
  input wire [4:0] reg_addr,
  input wire reg_write,
  input wire reg_read,
  input wire [7:0] reg_rdata,
  // flag outputs
  input wire overflow_irq,
  input wire [NUM_MODULES-1:0] module_irq,
  input wire watchdog_reset_req
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  // reads of the run and flags register and of mode registers
  sequence s_rd_flags; reg_read && reg_addr == 5'h00; endsequence
  sequence s_rd_mode; reg_read && reg_addr inside {[5'h08:5'h0c]}; endsequence
  property p_ovf_read; s_rd_flags ##0 overflow_irq |=> reg_rdata[7]; endproperty
  a_ovf_read: assert property (p_ovf_read) else $error("overflow flag read low");
  property p_ovf_keep; $fell(overflow_irq) |-> $past(reg_write); endproperty
  a_ovf_keep: assert property (p_ovf_keep) else $error("overflow dropped by itself");
  property p_evt_keep; |($past(module_irq) & ~module_irq) |-> $past(reg_write); endproperty
  a_evt_keep: assert property (p_evt_keep) else $error("event flag dropped by itself");
  property p_evt_read;
    s_rd_flags |=> (reg_rdata[4:0] & $past(module_irq)) == $past(module_irq);
  endproperty
  a_evt_read: assert property (p_evt_read) else $error("raised flag read low");
  property p_flag_gap; s_rd_flags |=> !reg_rdata[5]; endproperty
  a_flag_gap: assert property (p_flag_gap) else $error("unused flag bit set");
  property p_mode_top; s_rd_mode |=> !reg_rdata[7]; endproperty
  a_mode_top: assert property (p_mode_top) else $error("mode bit 7 read high");
  property p_wdog_pulse; $rose(watchdog_reset_req) |=> !watchdog_reset_req; endproperty
  a_wdog_pulse: assert property (p_wdog_pulse) else $error("reset request too long");
  property p_rd_quiet; !$past(reg_read) |-> reg_rdata == 8'h00; endproperty
  a_rd_quiet: assert property (p_rd_quiet) else $error("read data outside slot");
endmodule // counter_array_sva
bind counter_array counter_array_sva #(.NUM_MODULES(NUM_MODULES), .COUNT_WIDTH(COUNT_WIDTH))
  u_counter_array_sva (.sys_clk(sys_clk), .rst_b(rst_b), .reg_addr(reg_addr),
  .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
  .overflow_irq(overflow_irq), .module_irq(module_irq),
  .watchdog_reset_req(watchdog_reset_req));
`default_nettype wire

// ### dv/counter_array_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "counter_array_consts.vh"
module counter_array_tb;
  logic sys_clk, rst_b, reg_write, reg_read, cpu_idle, timer0_overflow;
  logic [4:0] reg_addr;
  logic [7:0] reg_wdata, d, x;
  logic [1:0] tick_prescale;
  logic [15:0] c, v;
  wire [7:0] reg_rdata;
  wire external_count_input, overflow_irq, watchdog_reset_req;
  wire [4:0] module_pin_in, module_pin_out, module_pin_oe, module_irq;
  int n_mismatch, comparisons, m_count, seed, n, n_wdog;
  logic [7:0] q_mode[$];
  logic [15:0] q_val[$];
  localparam logic [4:0] MB = `ADDR_MODE_BASE;
  localparam logic [4:0] VL = `ADDR_VAL_LO_BASE;
  localparam logic [4:0] VH = `ADDR_VAL_HI_BASE;
  counter_array u_counter_array (.sys_clk(sys_clk), .rst_b(rst_b), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
    .reg_rdata(reg_rdata), .cpu_idle(cpu_idle), .timer0_overflow(timer0_overflow),
    .tick_prescale(tick_prescale), .external_count_input(external_count_input),
    .module_pin_in(module_pin_in), .module_pin_out(module_pin_out),
    .module_pin_oe(module_pin_oe), .overflow_irq(overflow_irq),
    .module_irq(module_irq), .watchdog_reset_req(watchdog_reset_req));
  pin_partner u_pin_partner (.sys_clk(sys_clk), .external_count_input(external_count_input),
    .module_pin_in(module_pin_in));
  // clock
  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end
  // count reset request pulses
  always @(posedge sys_clk) if (watchdog_reset_req === 1'b1) n_wdog++;
  task chk(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task wr(input logic [4:0] a, input logic [7:0] w);
    @(posedge sys_clk);
    reg_addr <= a; reg_wdata <= w; reg_write <= 1'b1;
    @(posedge sys_clk) reg_write <= 1'b0;
    #1; // outputs launched by the write have settled
  endtask
  task rd(input logic [4:0] a);
    @(posedge sys_clk);
    reg_addr <= a; reg_read <= 1'b1;
    @(posedge sys_clk) reg_read <= 1'b0;
    #1 d = reg_rdata;
  endtask
  // low first, it freezes the high byte
  task rdc;
    rd(`ADDR_COUNT_LO); c[7:0] = d;
    rd(`ADDR_COUNT_HI); c[15:8] = d;
  endtask
  task setc(input logic [15:0] w);
    wr(`ADDR_COUNT_LO, w[7:0]); wr(`ADDR_COUNT_HI, w[15:8]); m_count = w;
  endtask
  task t0(input int k);
    repeat (k) begin
      @(posedge sys_clk) timer0_overflow <= 1'b1;
      @(posedge sys_clk) timer0_overflow <= 1'b0;
    end
  endtask
  task finish_test;
    $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
    if (n_mismatch == 0 && comparisons > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    #4000000 n_mismatch++;
    finish_test;
  end
  // main sequence
  initial begin
    seed = 32'hc86eabe0;
    {rst_b, reg_write, reg_read, cpu_idle, timer0_overflow} = 5'h00;
    reg_addr = 5'h00; reg_wdata = 8'h00; tick_prescale = 2'h0;
    repeat (3) @(posedge sys_clk);
    rst_b <= 1'b1;
    for (int a = 0; a < 32; a++) begin rd(5'(a)); chk(d, 8'h00); end
    for (int i = 0; i < 5; i++) begin
      x = $random(seed); v = $random(seed);
      wr(MB + 5'(i), x); wr(VL + 5'(i), v[7:0]); wr(VH + 5'(i), v[15:8]);
      q_mode.push_back({1'b0, x[6:0]}); q_val.push_back(v);
    end
    for (int i = 0; i < 5; i++) begin
      rd(MB + 5'(i)); chk(d, q_mode.pop_front());
      v = q_val.pop_front();
      rd(VL + 5'(i)); chk(d, v[7:0]);
      rd(VH + 5'(i)); chk(d, v[15:8]);
      wr(MB + 5'(i), 8'h00);
    end
    wr(`ADDR_RUN_FLAGS, 8'h00);
    for (int p = 0; p < 3; p++) begin
      @(posedge sys_clk) tick_prescale <= 2'(p);
      setc(16'h0000); wr(`ADDR_ARRAY_MODE, 8'h00); wr(`ADDR_RUN_FLAGS, 8'h40);
      repeat (16 << (2 * p)) @(posedge sys_clk);
      wr(`ADDR_RUN_FLAGS, 8'h00); rdc;
      chk(16'(c >= 4 && c <= 5), 16'h0001);
    end
    n = ($random(seed) & 7) + 1;
    setc(16'h1234); wr(`ADDR_ARRAY_MODE, 8'h04); t0(2);
    wr(`ADDR_RUN_FLAGS, 8'h40); t0(n); wr(`ADDR_RUN_FLAGS, 8'h00);
    m_count += n; rdc; chk(c, 16'(m_count));
    wr(`ADDR_ARRAY_MODE, 8'h84);
    @(posedge sys_clk) cpu_idle <= 1'b1;
    wr(`ADDR_RUN_FLAGS, 8'h40); t0(3);
    @(posedge sys_clk) cpu_idle <= 1'b0;
    t0(2); wr(`ADDR_RUN_FLAGS, 8'h00);
    m_count += 2; rdc; chk(c, 16'(m_count));
    wr(`ADDR_ARRAY_MODE, 8'h06); wr(`ADDR_RUN_FLAGS, 8'h40);
    u_pin_partner.ext_falls(4);
    repeat (3) @(posedge sys_clk);
    wr(`ADDR_RUN_FLAGS, 8'h00);
    m_count += 4; rdc; chk(c, 16'(m_count));
    wr(MB + 5'd1, 8'h11); wr(MB + 5'd2, 8'h20);
    u_pin_partner.pin_set(1, 1'b1); u_pin_partner.pin_set(2, 1'b1);
    u_pin_partner.pin_set(1, 1'b0);
    repeat (3) @(posedge sys_clk);
    chk(module_irq, 5'h02);
    rd(`ADDR_RUN_FLAGS); chk(d, 8'h06);
    rd(VL + 5'd1); chk(d, m_count[7:0]);
    rd(VH + 5'd2); chk(d, m_count[15:8]);
    wr(`ADDR_RUN_FLAGS, 8'hbd); chk(module_irq, 5'h00);
    wr(MB + 5'd1, 8'h00); wr(MB + 5'd2, 8'h00); wr(`ADDR_RUN_FLAGS, 8'h00);
    setc(16'h0100); wr(VL, 8'h02); wr(VH, 8'h01); wr(MB, 8'h4d);
    wr(`ADDR_ARRAY_MODE, 8'h04); wr(`ADDR_RUN_FLAGS, 8'h40); t0(3);
    repeat (3) @(posedge sys_clk);
    chk({module_irq[0], module_pin_out[0], module_pin_oe[0]}, 3'h7);
    wr(`ADDR_RUN_FLAGS, 8'h00); wr(MB, 8'h00);
    wr(VL + 5'd3, 8'h10); wr(VH + 5'd3, 8'h00); wr(MB + 5'd3, 8'h42);
    setc(16'h000f);
    repeat (2) @(posedge sys_clk);
    chk(module_pin_out[3], 1'b0);
    setc(16'h0010);
    repeat (2) @(posedge sys_clk);
    chk({module_pin_out[3], module_pin_oe[3]}, 2'h3);
    wr(`ADDR_ARRAY_MODE, 8'h05); setc(16'hffff); wr(`ADDR_RUN_FLAGS, 8'h40); t0(1);
    repeat (2) @(posedge sys_clk);
    chk(overflow_irq, 1'b1);
    wr(`ADDR_ARRAY_MODE, 8'h04); chk(overflow_irq, 1'b0);
    wr(`ADDR_ARRAY_MODE, 8'h05); wr(`ADDR_RUN_FLAGS, 8'hc0); t0(2);
    chk(overflow_irq, 1'b1);
    rd(`ADDR_RUN_FLAGS); chk(d[7:6], 2'h3);
    wr(`ADDR_RUN_FLAGS, 8'h00); chk(overflow_irq, 1'b0);
    setc(16'h0200); wr(VL + 5'd4, 8'h01); wr(VH + 5'd4, 8'h02); wr(MB + 5'd4, 8'h48);
    wr(`ADDR_ARRAY_MODE, 8'h44); wr(`ADDR_RUN_FLAGS, 8'h40); t0(1);
    repeat (5) @(posedge sys_clk);
    chk(16'(n_wdog), 16'h0001);
    // same match with the watchdog off raises only the flag
    wr(`ADDR_RUN_FLAGS, 8'h00); setc(16'h0200); wr(`ADDR_ARRAY_MODE, 8'h04);
    wr(`ADDR_RUN_FLAGS, 8'h40); t0(1);
    repeat (5) @(posedge sys_clk);
    chk(16'(n_wdog), 16'h0001);
    rd(`ADDR_RUN_FLAGS); chk(d[4], 1'b1);
    finish_test;
  end
endmodule // counter_array_tb
`default_nettype wire

// ### dv/pin_partner.sv
`timescale 1ns/1ps
`default_nettype none
module pin_partner (
  // clock
  input wire sys_clk,
  // pins into the array
  output logic external_count_input,
  output logic [4:0] module_pin_in
);
  // idle levels
  initial begin
    external_count_input = 1'b1;
    module_pin_in = 5'h00;
  end
  // falling edges, two cycles low and three high keeps a fifth rate
  task ext_falls(input int k);
    repeat (k) begin
      @(posedge sys_clk) external_count_input <= 1'b0;
      repeat (2) @(posedge sys_clk);
      external_count_input <= 1'b1;
      repeat (2) @(posedge sys_clk);
    end
  endtask
  // module i sits on pin i
  task pin_set(input int i, input logic v);
    @(posedge sys_clk) module_pin_in[i] <= v;
  endtask
endmodule // pin_partner
`default_nettype wire

// ### logic/counter_array.v
// Function
// - one 16-bit counter is the time base for five 16-bit modules
// - each module owns one pin, module 0 on the first pin
// - source 0x prescaled tick, 10 timer 0 overflow, 11 external input
// - external source counts on each falling edge of its pin
// - idle-stop set halts the counter while the processor idles
// - watchdog-enable switches the module 4 watchdog on or off
// - run bit 6 of run-and-flags register runs the counter
// - overflow sets flag bit 7; interrupt only when overflow irq enabled
// - only software clears the overflow flag
// - bits 0 to 4 are module event flags, set by hardware, cleared by software
// - each module has its own interrupt output
// - mode bit 0 lets the module event flag request an interrupt
// - mode bit 1 selects pulse width modulation
// - mode bit 2 toggles the module pin on each compare match
// - mode bit 3 sets the event flag on each compare match
// - mode bit 4 captures falling edges, bit 5 rising edges
// - mode bit 6 enables the comparator
// - each module holds a 16-bit value in high and low bytes
// - pulse width mode uses the stored value as duty cycle
`timescale 1ns/1ps
`default_nettype none
`include "counter_array_consts.vh"
module counter_array #(
  parameter NUM_MODULES = 5,
  parameter COUNT_WIDTH = 16
) (
  // clock and reset
  input wire sys_clk,
  input wire rst_b,
  // register port
  input wire [4:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_write,
  input wire reg_read,
  output reg [7:0] reg_rdata,
  // system inputs
  input wire cpu_idle,
  input wire timer0_overflow,
  input wire [1:0] tick_prescale,
  input wire external_count_input,
  // module pins (output-only compare, input-only capture)
  input wire [NUM_MODULES-1:0] module_pin_in,
  output wire [NUM_MODULES-1:0] module_pin_out,
  output wire [NUM_MODULES-1:0] module_pin_oe,
  // interrupt requests and watchdog reset
  output wire overflow_irq,
  output wire [NUM_MODULES-1:0] module_irq,
  output reg watchdog_reset_req
);
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  // match of counter against a module's stored value
  function match_fn;
    input [15:0] cnt;
    input [15:0] val;
    begin
      match_fn = (cnt == val);
    end
  endfunction

  // byte field select of an indexed register block
  function is_block;
    input [4:0] addr;
    input [4:0] base;
    begin
      is_block = (addr[4:3] == base[4:3]) && (addr[2:0] < 3'd5);
    end
  endfunction

  // address of one module's register inside an indexed block
  function slot_hit;
    input [4:0] addr;
    input [4:0] base;
    input [2:0] idx;
    begin
      slot_hit = (addr == (base | {2'b00, idx}));
    end
  endfunction

  // ----------------------------------------
  // state
  // ----------------------------------------
  reg overflow_flag_reg;
  reg run_bit_reg;
  reg [NUM_MODULES-1:0] event_flag_reg;
  reg [7:0] array_mode_reg;
  reg [COUNT_WIDTH-1:0] count_reg;
  reg [7:0] prescale_reg;
  reg [7:0] module_mode_reg [0:NUM_MODULES-1];
  reg [COUNT_WIDTH-1:0] module_value_reg [0:NUM_MODULES-1];
  reg [NUM_MODULES-1:0] toggle_pin_reg;
  reg [NUM_MODULES-1:0] pwm_pin_reg;
  reg [NUM_MODULES-1:0] match_seen_reg;
  reg [7:0] count_hi_shadow_reg;
  reg [NUM_MODULES-1:0] flag_src;
  wire [NUM_MODULES-1:0] flag_set;

  wire [NUM_MODULES-1:0] pin_rise;
  wire [NUM_MODULES-1:0] pin_fall;
  wire ext_rise_unused;
  wire ext_fall;
  wire ext_level_unused;
  wire [NUM_MODULES-1:0] pin_level_unused;

  // ----------------------------------------
  // edge detection on pins
  // ----------------------------------------
  // external count input, counted on falling edge
  edge_sense ext_edge (
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .pin_in(external_count_input),
    .rise(ext_rise_unused),
    .fall(ext_fall),
    .level(ext_level_unused)
  );

  genvar g;
  generate
    for (g = 0; g < NUM_MODULES; g = g + 1) begin : pin_edge
      // module capture pin edges
      edge_sense cap_edge (
        .sys_clk(sys_clk),
        .rst_b(rst_b),
        .pin_in(module_pin_in[g]),
        .rise(pin_rise[g]),
        .fall(pin_fall[g]),
        .level(pin_level_unused[g])
      );
    end
  endgenerate

  // ----------------------------------------
  // register write decode
  // ----------------------------------------
  // one strobe for each single register
  wire wr_run_flags = reg_write && (reg_addr == `ADDR_RUN_FLAGS);
  wire wr_array_mode = reg_write && (reg_addr == `ADDR_ARRAY_MODE);
  wire wr_count_lo = reg_write && (reg_addr == `ADDR_COUNT_LO);
  wire wr_count_hi = reg_write && (reg_addr == `ADDR_COUNT_HI);

  // ----------------------------------------
  // count source and counter
  // ----------------------------------------
  reg [7:0] div_sel;
  reg tick;
  reg count_en;

  // select prescale ratio and count source
  always @* begin
    case (tick_prescale)
      2'b00: div_sel = `DIV_BY_4;
      2'b01: div_sel = `DIV_BY_16;
      default: div_sel = `DIV_BY_64;
    endcase
    tick = (prescale_reg >= div_sel - 8'h01); // a ratio change never strands the prescaler
    case ({array_mode_reg[`AM_SRC_HI], array_mode_reg[`AM_SRC_LO]})
      2'b10: count_en = timer0_overflow;
      2'b11: count_en = ext_fall;
      default: count_en = tick;
    endcase
    count_en = count_en & run_bit_reg
      & ~(array_mode_reg[`AM_IDLE_STOP] & cpu_idle);
  end

  wire count_wrap = count_en && (count_reg == {COUNT_WIDTH{1'b1}});

  // prescaler and shared 16-bit counter
  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      prescale_reg <= 8'h00;
      count_reg <= {COUNT_WIDTH{1'b0}};
    end else begin
      if (tick) begin
        prescale_reg <= 8'h00;
      end else begin
        prescale_reg <= prescale_reg + 8'h01;
      end
      if (wr_count_lo) begin
        count_reg[7:0] <= reg_wdata;
      end else if (wr_count_hi) begin
        count_reg[15:8] <= reg_wdata;
      end else if (count_en) begin
        count_reg <= count_reg + 16'h0001;
      end
    end
  end

  // ----------------------------------------
  // per-module match, capture and pin logic
  // ----------------------------------------
  reg [NUM_MODULES-1:0] match_now;
  reg [NUM_MODULES-1:0] capture_now;
  reg [NUM_MODULES-1:0] wr_mode;
  reg [NUM_MODULES-1:0] wr_val_lo;
  reg [NUM_MODULES-1:0] wr_val_hi;
  integer i;
  integer j;
  integer k;
  integer w;

  // one strobe for each module register
  always @* begin
    for (w = 0; w < NUM_MODULES; w = w + 1) begin
      wr_mode[w] = reg_write && slot_hit(reg_addr, `ADDR_MODE_BASE, w[2:0]);
      wr_val_lo[w] = reg_write && slot_hit(reg_addr, `ADDR_VAL_LO_BASE, w[2:0]);
      wr_val_hi[w] = reg_write && slot_hit(reg_addr, `ADDR_VAL_HI_BASE, w[2:0]);
    end
  end

  // match on counter change; capture on enabled edge
  always @* begin
    match_now = {NUM_MODULES{1'b0}};
    capture_now = {NUM_MODULES{1'b0}};
    for (i = 0; i < NUM_MODULES; i = i + 1) begin
      match_now[i] = module_mode_reg[i][`MM_COMP_EN]
        && match_fn(count_reg, module_value_reg[i]) && !match_seen_reg[i];
      capture_now[i] = (module_mode_reg[i][`MM_CAP_FALL] && pin_fall[i])
        || (module_mode_reg[i][`MM_CAP_RISE] && pin_rise[i]);
    end
  end

  // match raises a flag only with flag-on-match; an enabled capture always does
  always @* begin
    for (k = 0; k < NUM_MODULES; k = k + 1) begin
      flag_src[k] = module_mode_reg[k][`MM_MATCH_FLAG];
    end
  end
  assign flag_set = (match_now & flag_src) | capture_now;

  // run bit, overflow and event flags: a write of zero clears, hardware set wins
  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      event_flag_reg <= {NUM_MODULES{1'b0}};
      overflow_flag_reg <= 1'b0;
      run_bit_reg <= 1'b0;
      array_mode_reg <= `RESET_BYTE;
      watchdog_reset_req <= 1'b0;
    end else begin
      if (wr_run_flags) begin
        run_bit_reg <= reg_wdata[`RF_RUN];
        overflow_flag_reg <= (reg_wdata[`RF_OVERFLOW] & overflow_flag_reg) | count_wrap;
        event_flag_reg <= (reg_wdata[NUM_MODULES-1:0] & event_flag_reg) | flag_set;
      end else begin
        if (count_wrap) begin
          overflow_flag_reg <= 1'b1;
        end
        event_flag_reg <= event_flag_reg | flag_set;
      end
      if (wr_array_mode) begin
        array_mode_reg <= reg_wdata;
      end
      watchdog_reset_req <= array_mode_reg[`AM_WDOG_EN] && match_now[NUM_MODULES-1];
    end
  end

  // stored values, capture loads and compare pin drivers per module
  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      for (j = 0; j < NUM_MODULES; j = j + 1) begin
        module_mode_reg[j] <= `RESET_BYTE;
        module_value_reg[j] <= {COUNT_WIDTH{1'b0}};
      end
      toggle_pin_reg <= {NUM_MODULES{1'b0}};
      pwm_pin_reg <= {NUM_MODULES{1'b0}};
      match_seen_reg <= {NUM_MODULES{1'b0}};
    end else begin
      for (j = 0; j < NUM_MODULES; j = j + 1) begin
        if (wr_mode[j]) begin
          module_mode_reg[j] <= {1'b0, reg_wdata[6:0]};
        end
        if (wr_val_lo[j]) begin
          module_value_reg[j][7:0] <= reg_wdata;
        end else if (wr_val_hi[j]) begin
          module_value_reg[j][15:8] <= reg_wdata;
        end else if (capture_now[j]) begin
          module_value_reg[j] <= count_reg;
        end
        match_seen_reg[j] <= match_fn(count_reg, module_value_reg[j]);
        if (match_now[j] && module_mode_reg[j][`MM_TOGGLE]) begin
          toggle_pin_reg[j] <= ~toggle_pin_reg[j];
        end
        pwm_pin_reg[j] <= (count_reg >= module_value_reg[j]);
      end
    end
  end

  // ----------------------------------------
  // pins and interrupts
  // ----------------------------------------
  reg [NUM_MODULES-1:0] pin_mux;
  reg [NUM_MODULES-1:0] oe_mux;
  reg [NUM_MODULES-1:0] irq_mux;
  integer p;

  // pin per module: pwm or toggle output, capture leaves pin undriven
  always @* begin
    for (p = 0; p < NUM_MODULES; p = p + 1) begin
      pin_mux[p] = module_mode_reg[p][`MM_PWM] ? pwm_pin_reg[p]
        : toggle_pin_reg[p];
      oe_mux[p] = module_mode_reg[p][`MM_PWM] | module_mode_reg[p][`MM_TOGGLE];
      irq_mux[p] = event_flag_reg[p] & module_mode_reg[p][`MM_IRQ_EN];
    end
  end

  assign module_pin_out = pin_mux;
  assign module_pin_oe = oe_mux;
  assign module_irq = irq_mux;
  assign overflow_irq = overflow_flag_reg & array_mode_reg[`AM_OVF_IRQ_EN];

  // ----------------------------------------
  // register read
  // ----------------------------------------
  // read data one cycle after the read strobe
  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      reg_rdata <= 8'h00;
      count_hi_shadow_reg <= 8'h00;
    end else begin
      reg_rdata <= 8'h00;
      if (reg_read) begin
        if (reg_addr == `ADDR_RUN_FLAGS) begin
          reg_rdata <= {overflow_flag_reg, run_bit_reg, 1'b0, event_flag_reg};
        end else if (reg_addr == `ADDR_ARRAY_MODE) begin
          reg_rdata <= array_mode_reg;
        end else if (reg_addr == `ADDR_COUNT_LO) begin
          reg_rdata <= count_reg[7:0];
          count_hi_shadow_reg <= count_reg[15:8];
        end else if (reg_addr == `ADDR_COUNT_HI) begin
          reg_rdata <= count_hi_shadow_reg;
        end else if (is_block(reg_addr, `ADDR_MODE_BASE)) begin
          reg_rdata <= module_mode_reg[reg_addr[2:0]];
        end else if (is_block(reg_addr, `ADDR_VAL_LO_BASE)) begin
          reg_rdata <= module_value_reg[reg_addr[2:0]][7:0];
        end else if (is_block(reg_addr, `ADDR_VAL_HI_BASE)) begin
          reg_rdata <= module_value_reg[reg_addr[2:0]][15:8];
        end
      end
    end
  end
endmodule // counter_array
`default_nettype wire

// ### logic/edge_sense.v
`timescale 1ns/1ps
`default_nettype none
module edge_sense (
  // clock and reset
  input wire sys_clk,
  input wire rst_b,
  // pin in and edges out
  input wire pin_in,
  output wire rise,
  output wire fall,
  output wire level
);
  reg last_reg;

  // previous pin level
  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      last_reg <= 1'b0;
    end else begin
      last_reg <= pin_in;
    end
  end

  assign rise = pin_in & ~last_reg;
  assign fall = ~pin_in & last_reg;
  assign level = last_reg;
endmodule // edge_sense
`default_nettype wire
